// >>> rtl/interval_countdown_timer.sv
// Interval countdown timer on a programmed I/O channel.
// Assumes host strobes are one-cycle pulses on I_REF_CLK; straps are async.
`timescale 1ns/1ps
module interval_countdown_timer
   import rtc_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
)(
   input  wire logic               I_REF_CLK,
   input  wire logic               I_RESETN,
   input  wire logic [1:0]         I_SLOT_CODE,
   input  wire logic [LEVEL_W-1:0] I_IRQ_LEVEL,
   input  wire logic [1:0]         I_UNIT,
   input  wire logic               I_COMMAND_OUT_OP,
   input  wire logic               I_STATUS_IN_OP,
   input  wire logic               I_DATA_BYTE_OUT_OP,
   input  wire logic               I_DATA_BYTE_IN_OP,
   input  wire logic [7:0]         I_WDATA,
   output logic [7:0]              O_RDATA,
   output logic                    O_RVALID,
   output logic                    O_IRQ,
   output logic [LEVEL_W-1:0]      O_IRQ_LEVEL,
   output logic [1:0]              O_UNIT_CODE
);

   // ***************************************************
   // Declarations
   // ***************************************************
   logic [1:0]         slot_s1;
   logic [1:0]         slot_s2;
   logic [LEVEL_W-1:0] lvl_s1;
   logic [LEVEL_W-1:0] lvl_s2;
   logic [1:0]         sync_vld;
   logic               strap_done;
   logic [3:0]         ctrl;
   logic               run;
   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] preset;
   logic [COUNT_W-1:0] shadow;
   logic [COUNT_W-1:0] snap;
   logic [1:0]         seq;
   seq_mode_e          mode;
   logic               tick;

   // ***************************************************
   // Strap capture
   // ***************************************************
   // Straps are pins, so two flops before use; sync_vld marks stage 2 filled
   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         sync_vld <= '0;
         slot_s1  <= '0;
         slot_s2  <= '0;
         lvl_s1   <= '0;
         lvl_s2   <= '0;
      end else begin
         sync_vld <= {sync_vld[0], 1'b1};
         slot_s1 <= I_SLOT_CODE;
         slot_s2 <= slot_s1;
         lvl_s1  <= I_IRQ_LEVEL;
         lvl_s2  <= lvl_s1;
      end
   end

   // Latch unit and level once, after the synchroniser settled
   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         strap_done  <= 1'b0;
         O_UNIT_CODE <= UNIT_INVALID;
         O_IRQ_LEVEL <= '0;
      end else if (!strap_done && sync_vld[1]) begin
         strap_done  <= 1'b1;
         O_UNIT_CODE <= slot_s2;
         O_IRQ_LEVEL <= lvl_s2;
      end
   end

   // ***************************************************
   // Access decode
   // ***************************************************
   // Slot 11 is not a legal position, so the unit never answers there
   wire sel      = strap_done && (O_UNIT_CODE != UNIT_INVALID)
                   && (I_UNIT == O_UNIT_CODE);
   wire cmd_wr   = sel && I_COMMAND_OUT_OP;
   wire stat_rd  = sel && I_STATUS_IN_OP && !I_COMMAND_OUT_OP;
   wire data_wr  = sel && I_DATA_BYTE_OUT_OP && !I_COMMAND_OUT_OP;
   wire data_rd  = sel && I_DATA_BYTE_IN_OP && !I_COMMAND_OUT_OP;
   // Levels 0 and 1 are reserved, so the request is withheld there
   wire lvl_ok   = (O_IRQ_LEVEL >= LEVEL_MIN);

   // Control bits seen by this command: fresh if sampled, else stored
   wire [3:0] next_ctrl = I_WDATA[CMD_SAMPLE] ? I_WDATA[3:0] : ctrl;
   wire [1:0] bcnt      = ctrl[CMD_BCNT_LO +: 2];
   wire       auto_rst  = ctrl[CMD_AUTO];
   wire       int_en    = ctrl[CMD_INT_EN];

   // ***************************************************
   // Timebase
   // ***************************************************
   rtc_timebase #(
      .DIVIDE   (TICK_DIV)
   ) u_timebase (
      .i_clk    (I_REF_CLK),
      .i_resetn (I_RESETN),
      .o_tick   (tick)
   );

   // Zero reached on this tick; start edge is not aligned, hence up to 1 tick early
   wire dec      = tick && run && (count != '0);
   wire zero_evt = dec && (count == COUNT_W'(1));

   // ***************************************************
   // Preset byte assembly
   // ***************************************************
   // Shift in MSB first; fewer bytes leave upper bytes zero
   wire [COUNT_W-1:0] next_shadow = {shadow[COUNT_W-BYTE_W-1:0], I_WDATA};
   wire               last_byte   = (seq + 2'd1 == bcnt);
   wire               load_done   = (mode == SEQ_LOAD) && data_wr
                                    && last_byte;

   // Snapshot byte for present step, MSB of the n-byte field first
   wire [1:0] snap_idx = bcnt - seq - 2'd1;
   wire [7:0] snap_byte = snap[snap_idx * BYTE_W +: BYTE_W];

   // ***************************************************
   // Command register
   // ***************************************************
   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         ctrl <= CTRL_RESET;
         run  <= 1'b0;
      end else if (cmd_wr) begin
         ctrl <= next_ctrl;
         run  <= I_WDATA[CMD_RUN];
      end
   end

   // ***************************************************
   // Byte sequencer
   // ***************************************************
   // A new preset or snapshot command restarts at the top byte
   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         mode   <= SEQ_IDLE;
         seq    <= 2'd0;
         shadow <= '0;
      end else if (cmd_wr && (I_WDATA[CMD_PRESET] || I_WDATA[CMD_SNAP])) begin
         mode   <= I_WDATA[CMD_PRESET] ? SEQ_LOAD : SEQ_SNAP;
         seq    <= 2'd0;
         shadow <= '0;
      end else begin
         case (mode)
            SEQ_LOAD: begin
               if (data_wr) begin
                  shadow <= next_shadow;
                  seq    <= seq + 2'd1;
                  if (last_byte || bcnt == 2'd0) begin
                     mode <= SEQ_IDLE;
                  end
               end
            end
            SEQ_SNAP: begin
               if (zero_evt) begin
                  mode <= SEQ_IDLE;
               end else if (data_rd) begin
                  seq <= seq + 2'd1;
                  if (last_byte || bcnt == 2'd0) begin
                     mode <= SEQ_IDLE;
                  end
               end
            end
            default: begin
               mode <= SEQ_IDLE;
            end
         endcase
      end
   end

   // ***************************************************
   // Counter, preset and snapshot
   // ***************************************************
   // Loading wins over the tick; the host asked for the new value
   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         count  <= '0;
         preset <= '0;
      end else if (load_done) begin
         count  <= next_shadow;
         preset <= next_shadow;
      end else if (zero_evt) begin
         count  <= auto_rst ? preset : '0;
      end else if (dec) begin
         count  <= count - COUNT_W'(1);
      end
   end

   // Snapshot copy leaves the counter alone
   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         snap <= '0;
      end else if (cmd_wr && I_WDATA[CMD_SNAP]) begin
         snap <= count;
      end
   end

   // ***************************************************
   // Host answers and interrupt
   // ***************************************************
   // Read data answers one cycle after the strobe
   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_RDATA  <= 8'h00;
         O_RVALID <= 1'b0;
      end else begin
         O_RVALID <= stat_rd || data_rd;
         if (stat_rd) begin
            O_RDATA <= STATUS_ONLINE;
         end else if (data_rd) begin
            O_RDATA <= (mode == SEQ_SNAP) ? snap_byte : 8'h00;
         end
      end
   end

   // One pulse per zero event, gated by enable and a legal level
   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_IRQ <= 1'b0;
      end else begin
         O_IRQ <= zero_evt && int_en && lvl_ok;
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   property p_irq_cause;
      @(posedge I_REF_CLK) disable iff (!I_RESETN)
      O_IRQ |-> $past(zero_evt) && $past(int_en);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("irq without enabled zero event");

   property p_no_irq_dis;
      @(posedge I_REF_CLK) disable iff (!I_RESETN)
      (zero_evt && !int_en) |=> !O_IRQ;
   endproperty
   a_no_irq_dis: assert property (p_no_irq_dis)
      else $error("irq while disabled");

   property p_dec_step;
      @(posedge I_REF_CLK) disable iff (!I_RESETN)
      (dec && !zero_evt && !load_done) |=> count == $past(count) - COUNT_W'(1);
   endproperty
   a_dec_step: assert property (p_dec_step)
      else $error("count did not step by one");

   // A preset landing right after the zero event may move the count legally
   property p_hold_zero;
      @(posedge I_REF_CLK) disable iff (!I_RESETN)
      (zero_evt && !auto_rst && !load_done) |=> count == '0 ##1 (count == '0 || $past(load_done));
   endproperty
   a_hold_zero: assert property (p_hold_zero)
      else $error("count left zero without restart");

   property p_reload;
      @(posedge I_REF_CLK) disable iff (!I_RESETN)
      (zero_evt && auto_rst && !load_done) |=> count == $past(preset);
   endproperty
   a_reload: assert property (p_reload)
      else $error("auto restart missed preset");

   property p_stop;
      @(posedge I_REF_CLK) disable iff (!I_RESETN)
      (cmd_wr && !I_WDATA[CMD_RUN]) |=> !run [*2] or (cmd_wr ##1 1);
   endproperty
   a_stop: assert property (p_stop)
      else $error("counting not stopped");

   property p_sample;
      @(posedge I_REF_CLK) disable iff (!I_RESETN)
      (cmd_wr && !I_WDATA[CMD_SAMPLE]) |=> $stable(ctrl);
   endproperty
   a_sample: assert property (p_sample)
      else $error("ctrl bits changed without sample");

   property p_snap;
      @(posedge I_REF_CLK) disable iff (!I_RESETN)
      (cmd_wr && I_WDATA[CMD_SNAP]) |=> snap == $past(count);
   endproperty
   a_snap: assert property (p_snap)
      else $error("snapshot not taken");

   property p_snap_end;
      @(posedge I_REF_CLK) disable iff (!I_RESETN)
      (mode == SEQ_SNAP && zero_evt && !cmd_wr) |=> mode == SEQ_IDLE;
   endproperty
   a_snap_end: assert property (p_snap_end)
      else $error("snapshot mode survived zero");

   property p_status;
      @(posedge I_REF_CLK) disable iff (!I_RESETN)
      stat_rd |=> O_RVALID && O_RDATA == STATUS_ONLINE;
   endproperty
   a_status: assert property (p_status)
      else $error("status not on-line");

   property p_restart;
      @(posedge I_REF_CLK) disable iff (!I_RESETN)
      (cmd_wr && (I_WDATA[CMD_PRESET] || I_WDATA[CMD_SNAP])) |=> seq == 2'd0;
   endproperty
   a_restart: assert property (p_restart)
      else $error("sequencer not restarted");

endmodule // interval_countdown_timer

// >>> rtl/rtc_pkg.sv
// Constants shared by the interval countdown timer and its timebase.
// Assumes a single 125 MHz clock and a host on the same clock.
package rtc_pkg;

   // Timing
   localparam int          CLK_FREQ_HZ     = 125_000_000;
   localparam int          TIMEBASE_HZ     = 100_000;
   localparam int          TICK_CYCLES     = CLK_FREQ_HZ / TIMEBASE_HZ;

   // Widths
   localparam int          COUNT_W         = 24;
   localparam int          BYTE_W          = 8;
   localparam int          LEVEL_W         = 5;

   // Command word fields
   localparam int          CMD_INT_EN      = 0;
   localparam int          CMD_AUTO        = 1;
   localparam int          CMD_BCNT_LO     = 2;
   localparam int          CMD_SAMPLE      = 4;
   localparam int          CMD_SNAP        = 5;
   localparam int          CMD_PRESET      = 6;
   localparam int          CMD_RUN         = 7;

   // Status and reset values
   localparam logic [7:0]  STATUS_ONLINE   = 8'h01;
   localparam logic [3:0]  CTRL_RESET      = 4'h0;
   localparam logic [1:0]  UNIT_INVALID    = 2'h3;
   localparam logic [4:0]  LEVEL_MIN       = 5'h02;

   // Byte sequencer modes
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_LOAD = 2'b01,
      SEQ_SNAP = 2'b10
   } seq_mode_e;

endpackage

// >>> rtl/rtc_timebase.sv
// Free running divider producing the 100 kHz counting enable.
// Assumes one clock; nothing in the host path may stop it.
`timescale 1ns/1ps
module rtc_timebase
   import rtc_pkg::*;
#(
   parameter int DIVIDE = TICK_CYCLES
)(
   input  wire logic i_clk,
   input  wire logic i_resetn,
   output logic      o_tick
);

   localparam int          CW   = $clog2(DIVIDE);
   localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

   logic [CW-1:0] cnt;
   wire           wrap = (cnt == LAST);

   // ***************************************************
   // Divider, never reset by commands
   // ***************************************************
   // One-cycle pulse every DIVIDE cycles
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt    <= '0;
         o_tick <= 1'b0;
      end else begin
         cnt    <= wrap ? '0 : cnt + 1'b1;
         o_tick <= wrap;
      end
   end

   property p_tick_period;
      @(posedge i_clk) disable iff (!i_resetn)
      o_tick |=> !o_tick;
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("tick wider than one cycle");

endmodule // rtc_timebase

// >>> verif/interval_countdown_timer_tb.sv
// Self-checking bench for the interval countdown timer.
// Assumes the host model drives all channel strobes; straps set per reset.
`timescale 1ns/1ps
module interval_countdown_timer_tb
   import rtc_pkg::*;
;
   localparam int TDIV = 8;
   logic               clk;
   logic               rst_n;
   logic [1:0]         slot;
   logic [LEVEL_W-1:0] level;
   logic [7:0]         d, d1;
   logic               v, seen;
   int                 n_errors, n_checks, n;
   // Nets between host model and timer, driven by their outputs
   wire  [1:0]         unit;
   wire                cmd, stat, dout, din, rvalid, irq;
   wire  [7:0]         wdata, rdata;
   wire  [LEVEL_W-1:0] irq_level;
   wire  [1:0]         unit_code;

   interval_countdown_timer #(.TICK_DIV(TDIV)) i_interval_countdown_timer (
      .I_REF_CLK(clk), .I_RESETN(rst_n), .I_SLOT_CODE(slot), .I_IRQ_LEVEL(level),
      .I_UNIT(unit), .I_COMMAND_OUT_OP(cmd), .I_STATUS_IN_OP(stat),
      .I_DATA_BYTE_OUT_OP(dout), .I_DATA_BYTE_IN_OP(din), .I_WDATA(wdata),
      .O_RDATA(rdata), .O_RVALID(rvalid), .O_IRQ(irq), .O_IRQ_LEVEL(irq_level),
      .O_UNIT_CODE(unit_code));

   programmed_io_channel_host_model i_programmed_io_channel_host_model (
      .i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_unit(unit), .o_cmd(cmd),
      .o_stat(stat), .o_dout(dout), .o_din(din), .o_wdata(wdata));

   //**********************************************************************
   // Clock, compare and sequence helpers
   //**********************************************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic check1(input string what, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", what, e, g);
      end
   endtask

   // Reset held three cycles; first request only from the fourth edge
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check8("unit code in reset", 8'h03, {6'h00, unit_code});
      rst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
   endtask

   task automatic snap_read(input int cnt, input logic [23:0] e);
      for (int i = cnt - 1; i >= 0; i--) begin
         i_programmed_io_channel_host_model.read(3, d, v);
         check1("data rvalid", 1'b1, v);
         check8("snapshot byte", e[8*i+:8], d);
      end
   endtask

   // Bounded wait for the one-cycle interrupt pulse
   task automatic wait_irq(input int lim);
      n = 0;
      seen = 1'b0;
      while (!seen && n < lim) begin
         @(posedge clk);
         #1;
         n++;
         seen = (irq === 1'b1);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run of about 600 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      finish_test();
   end

   //**********************************************************************
   // Tests
   //**********************************************************************
   initial begin
      rst_n = 1'b0;
      slot = 2'h2;
      level = 5'h16;
      n_errors = 0;
      n_checks = 0;
      do_reset();
      i_programmed_io_channel_host_model.use_unit(2'h2);
      i_programmed_io_channel_host_model.read(1, d, v);
      check8("status", STATUS_ONLINE, d);
      check8("unit code", 8'h02, {6'h00, unit_code});
      check8("irq level", 8'h16, {3'h0, irq_level});
      i_programmed_io_channel_host_model.use_unit(2'h1);
      i_programmed_io_channel_host_model.read(1, d, v);
      check1("other unit ignored", 1'b0, v);
      i_programmed_io_channel_host_model.use_unit(2'h2);
      $display("test status done");
      // Stopped counter: full preset, snapshot with stored count kept
      i_programmed_io_channel_host_model.preset(8'h5c, 24'h0a0b0c, 3);
      i_programmed_io_channel_host_model.command(8'h20);
      snap_read(3, 24'h0a0b0c);
      snap_read(1, 24'h000000);
      // Two-byte preset clears the top byte; bit 4 clear keeps byte count
      i_programmed_io_channel_host_model.preset(8'h58, 24'hff1234, 2);
      i_programmed_io_channel_host_model.command(8'h3c);
      snap_read(3, 24'h001234);
      i_programmed_io_channel_host_model.command(8'h24);
      snap_read(3, 24'h001234);
      $display("test preset done");
      // Hold mode: one interrupt, then counter rests at zero
      i_programmed_io_channel_host_model.preset(8'h55, 24'h000003, 1);
      i_programmed_io_channel_host_model.command(8'h80);
      wait_irq(200);
      check1("zero irq", 1'b1, seen);
      wait_irq(100);
      check1("no restart irq", 1'b0, seen);
      i_programmed_io_channel_host_model.command(8'h20);
      snap_read(1, 24'h000000);
      $display("test hold done");
      // Auto restart: period of three ticks between interrupts
      i_programmed_io_channel_host_model.preset(8'h57, 24'h000003, 1);
      i_programmed_io_channel_host_model.command(8'h80);
      wait_irq(200);
      wait_irq(200);
      check1("restart period", 1'b1, seen && n == 3 * TDIV);
      i_programmed_io_channel_host_model.command(8'ha0);
      wait_irq(200);
      snap_read(1, 24'h000000);
      // Bit 7 clear stops the count
      i_programmed_io_channel_host_model.command(8'h20);
      i_programmed_io_channel_host_model.read(3, d1, v);
      wait_irq(60);
      check1("stopped no irq", 1'b0, seen);
      i_programmed_io_channel_host_model.command(8'h20);
      i_programmed_io_channel_host_model.read(3, d, v);
      check8("held count", d1, d);
      $display("test auto done");
      // Interrupt disabled while restarting
      i_programmed_io_channel_host_model.preset(8'h56, 24'h000002, 1);
      i_programmed_io_channel_host_model.command(8'h80);
      wait_irq(100);
      check1("irq disabled", 1'b0, seen);
      // Second reset in mid-run: slot 0 and a forbidden level
      slot  = 2'h0;
      level = 5'h01;
      do_reset();
      i_programmed_io_channel_host_model.use_unit(2'h0);
      check8("unit code slot 0", 8'h00, {6'h00, unit_code});
      check8("irq level low", 8'h01, {3'h0, irq_level});
      i_programmed_io_channel_host_model.preset(8'h55, 24'h000002, 1);
      i_programmed_io_channel_host_model.command(8'h80);
      wait_irq(100);
      check1("level 1 no irq", 1'b0, seen);
      i_programmed_io_channel_host_model.read(1, d, v);
      check1("status slot 0", 1'b1, v);
      $display("test level done");
      // Illegal slot position: the unit never answers
      slot = 2'h3;
      do_reset();
      i_programmed_io_channel_host_model.use_unit(2'h3);
      check8("unit code slot 3", 8'h03, {6'h00, unit_code});
      i_programmed_io_channel_host_model.read(1, d, v);
      check1("slot 3 silent", 1'b0, v);
      $display("test slot done");
      finish_test();
   end
endmodule // interval_countdown_timer_tb

// >>> verif/programmed_io_channel_host_model.sv
// Host model of the programmed I/O channel: four one-cycle strobe operations.
// Assumes the timer answers a read exactly one cycle after its strobe.
`timescale 1ns/1ps
module programmed_io_channel_host_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rvalid,
   output logic [1:0]      o_unit,
   output logic            o_cmd,
   output logic            o_stat,
   output logic            o_dout,
   output logic            o_din,
   output logic [7:0]      o_wdata
);
   //**********************************************************************
   // Strobe engine
   //**********************************************************************
   logic [3:0] stb;

   // Strobes idle low; unit code set by the bench
   assign o_cmd  = stb[0];
   assign o_stat = stb[1];
   assign o_dout = stb[2];
   assign o_din  = stb[3];

   initial begin
      stb     = 4'h0;
      o_unit  = 2'h0;
      o_wdata = 8'h00;
   end

   // One pulse; write data is inverted once released so stale bytes never match
   task automatic pulse(input int kind, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_wdata = d;
      stb     = 4'h1 << kind;
      @(posedge i_clk);
      #1;
      stb     = 4'h0;
      o_wdata = ~d;
   endtask

   task automatic use_unit(input logic [1:0] u);
      o_unit = u;
   endtask

   task automatic command(input logic [7:0] c);
      pulse(0, c);
   endtask

   // Command with preset bit, then n bytes most significant first
   task automatic preset(input logic [7:0] c, input logic [23:0] v, input int n);
      command(c);
      for (int i = n - 1; i >= 0; i--) begin
         pulse(2, v[8*i+:8]);
      end
   endtask

   // Status (kind 1) or one data byte (kind 3); answer taken one cycle on
   task automatic read(input int kind, output logic [7:0] d, output logic v);
      pulse(kind, 8'h00);
      d = i_rdata;
      v = i_rvalid;
   endtask
endmodule // programmed_io_channel_host_model
